/* design/dmae_engine.sv */
`timescale 1ns/1ps
module dmae_engine #(
  parameter int CNT_W = 14
) (
  // System clock and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Test clock and data-register port from the TAP.
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire logic dr_capture_i,
  input wire logic dr_shift_i,
  input wire logic dr_update_i,
  output logic tdo_o,
  output logic ready_o,
  // System bus master.
  output logic bus_valid_o,
  output dmae_pkg::dmae_bus_req_t bus_req_o,
  input wire logic bus_ack_i,
  input wire logic bus_err_i,
  input wire logic [31:0] bus_rdata_i
);

  // The count field width is fixed by the register layout.
  if (CNT_W != dmae_pkg::CNT_W) begin : g_chk
    $error("CNT_W must match the count field width");
  end

  // Test clock side state.
  logic rst_meta_r;
  logic rst_tck_r;
  logic [31:0] shift_r;
  logic data_pass_r;
  logic [6:0] idx_r;
  logic wr_sel_r;
  logic [31:0] ctrl_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic [31:0] cur_addr_r;
  logic [CNT_W:0] beats_r;
  logic armed_r;
  logic busy_r;
  logic go_tgl_r;
  logic ready_r;
  dmae_pkg::dmae_bus_req_t req_r;

  // System clock side state.
  dmae_pkg::dmae_bus_st_t bus_st_r;
  logic bus_valid_r;
  dmae_pkg::dmae_bus_req_t bus_req_r;
  logic [31:0] rsp_data_r;
  logic rsp_err_r;
  logic done_tgl_r;

  // Cross-domain event pulses.
  logic go_sys_p;
  logic done_tck_p;

  // Decoded port strobes.
  logic wr_ctrl;
  logic wr_addr;
  logic wr_data;
  logic rd_data;

  // Decoded new control word and launch terms.
  logic [31:0] new_ctrl;
  logic new_map_ok;
  logic [CNT_W-1:0] new_cnt;
  logic [CNT_W-1:0] cnt_one;
  logic [CNT_W:0] init_beats;
  logic [31:0] start_addr;
  logic go_rd0;
  logic go_wr;
  logic go_rdn;
  logic go;
  logic [31:0] cfg;
  logic [31:0] rd_val;
  logic last_beat;
  logic [31:0] step;

  // The test clock side gets its own copy of the system reset.
  always_ff @(posedge tck_i) begin
    rst_meta_r <= sys_rst_i;
    rst_tck_r <= rst_meta_r;
  end

  // Port strobes in the data pass of a selected register.
  assign wr_ctrl = dr_update_i && data_pass_r && wr_sel_r
    && idx_r == dmae_pkg::IDX_CTRL;
  assign wr_addr = dr_update_i && data_pass_r && wr_sel_r
    && idx_r == dmae_pkg::IDX_ADDR;
  assign wr_data = dr_update_i && data_pass_r && wr_sel_r
    && idx_r == dmae_pkg::IDX_DATA;
  assign rd_data = dr_capture_i && data_pass_r && !wr_sel_r
    && idx_r == dmae_pkg::IDX_DATA;

  // Read mux for the capture of a data pass.
  always_comb begin
    unique case (idx_r)
      dmae_pkg::IDX_CTRL: rd_val = ctrl_r;
      dmae_pkg::IDX_ADDR: rd_val = addr_r;
      dmae_pkg::IDX_DATA: rd_val = data_r;
      default: rd_val = dmae_pkg::REG_RESET;
    endcase
  end

  // Shift register: loads on a read capture, shifts LSB first.
  always_ff @(posedge tck_i) begin
    if (rst_tck_r) begin
      shift_r <= dmae_pkg::REG_RESET;
    end else if (dr_capture_i && data_pass_r && !wr_sel_r) begin
      shift_r <= rd_val;
    end else if (dr_shift_i) begin
      shift_r <= {tdi_i, shift_r[31:1]};
    end
  end

  // The serial output is the shift register's low bit.
  assign tdo_o = shift_r[0];

  // Alternate selector and data passes; the selector lands in bits 31..24.
  always_ff @(posedge tck_i) begin
    if (rst_tck_r) begin
      data_pass_r <= 1'b0;
      idx_r <= 7'h00;
      wr_sel_r <= 1'b0;
    end else if (dr_update_i) begin
      data_pass_r <= !data_pass_r;
      if (!data_pass_r) begin
        idx_r <= shift_r[31:25];
        wr_sel_r <= shift_r[32-dmae_pkg::SEL_W];
      end
    end
  end

  // The address register takes every write; the walk copies it.
  always_ff @(posedge tck_i) begin
    if (rst_tck_r) begin
      addr_r <= dmae_pkg::REG_RESET;
    end else if (wr_addr) begin
      addr_r <= shift_r;
    end
  end

  // Decode of a freshly written control word.
  assign new_ctrl = shift_r & dmae_pkg::CTRL_WMASK;
  assign new_map_ok = new_ctrl[dmae_pkg::MAP_HI:dmae_pkg::MAP_LO]
    == dmae_pkg::MAP_PRIMARY;
  assign new_cnt = new_ctrl[dmae_pkg::CNT_HI:dmae_pkg::CNT_LO];
  assign cnt_one = (new_cnt == '0) ? CNT_W'(1) : new_cnt;
  // A doubleword is carried as two word beats.
  assign init_beats = (new_ctrl[dmae_pkg::WID_HI:dmae_pkg::WID_LO]
    == dmae_pkg::WID_DWORD) ? {cnt_one, 1'b0}
    : {1'b0, cnt_one};
  assign start_addr = new_ctrl[dmae_pkg::BURST_BIT]
    ? (addr_r & dmae_pkg::BURST_ALIGN) : addr_r;

  // Launch terms: a read starts on the control write, a write on each
  // data write, and each later read beat when the tool fetches data.
  assign go_rd0 = wr_ctrl && !busy_r && new_ctrl[dmae_pkg::START_BIT]
    && new_map_ok && !new_ctrl[dmae_pkg::DIR_BIT];
  assign go_wr = wr_data && !busy_r && armed_r
    && ctrl_r[dmae_pkg::DIR_BIT];
  assign go_rdn = rd_data && !busy_r && armed_r
    && !ctrl_r[dmae_pkg::DIR_BIT] && ctrl_r[dmae_pkg::VALID_BIT];
  assign go = go_rd0 || go_wr || go_rdn;
  assign cfg = go_rd0 ? new_ctrl : ctrl_r;
  assign last_beat = beats_r == (CNT_W+1)'(1);

  // Address step per beat follows the width.
  always_comb begin
    unique case (ctrl_r[dmae_pkg::WID_HI:dmae_pkg::WID_LO])
      dmae_pkg::WID_BYTE: step = 32'h0000_0001;
      dmae_pkg::WID_HALF: step = 32'h0000_0002;
      default: step = 32'h0000_0004;
    endcase
  end

  // Request held stable for the system side until the answer returns.
  always_ff @(posedge tck_i) begin
    if (rst_tck_r) begin
      req_r <= '0;
      go_tgl_r <= 1'b0;
    end else if (go) begin
      go_tgl_r <= !go_tgl_r;
      req_r.addr <= go_rd0 ? start_addr : cur_addr_r;
      req_r.wdata <= shift_r;
      req_r.we <= cfg[dmae_pkg::DIR_BIT];
      unique case (cfg[dmae_pkg::WID_HI:dmae_pkg::WID_LO])
        dmae_pkg::WID_BYTE: req_r.size <= dmae_pkg::BSZ_BYTE;
        dmae_pkg::WID_HALF: req_r.size <= dmae_pkg::BSZ_HALF;
        default: req_r.size <= dmae_pkg::BSZ_WORD;
      endcase
      req_r.hi_prio <= cfg[dmae_pkg::PRIO_HI:dmae_pkg::PRIO_LO]
        == dmae_pkg::PRIO_HIGH;
      req_r.burst <= cfg[dmae_pkg::BURST_BIT];
    end
  end

  // Completion returns as a toggle from the system side.
  dmae_pulse_sync u_done_sync (
    .clk_i(tck_i),
    .rst_i(rst_tck_r),
    .tgl_i(done_tgl_r),
    .pulse_o(done_tck_p)
  );

  // Transfer engine: registers, status and the beat walk.
  always_ff @(posedge tck_i) begin
    if (rst_tck_r) begin
      ctrl_r <= dmae_pkg::REG_RESET;
      data_r <= dmae_pkg::REG_RESET;
      cur_addr_r <= dmae_pkg::REG_RESET;
      beats_r <= '0;
      armed_r <= 1'b0;
      busy_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (done_tck_p) begin
      busy_r <= 1'b0;
      cur_addr_r <= cur_addr_r + step;
      beats_r <= beats_r - (CNT_W+1)'(1);
      if (rsp_err_r) begin
        ctrl_r[dmae_pkg::FAULT_BIT] <= 1'b1;
        ctrl_r[dmae_pkg::VALID_BIT] <= 1'b0;
        ctrl_r[dmae_pkg::START_BIT] <= 1'b0;
        armed_r <= 1'b0;
      end else begin
        if (!ctrl_r[dmae_pkg::DIR_BIT]) begin
          data_r <= rsp_data_r;
          ctrl_r[dmae_pkg::VALID_BIT] <= 1'b1;
        end else begin
          ctrl_r[dmae_pkg::VALID_BIT] <= !last_beat;
        end
        if (last_beat) begin
          ctrl_r[dmae_pkg::START_BIT] <= 1'b0;
          armed_r <= 1'b0;
          ready_r <= 1'b1;
        end
      end
    end else begin
      if (wr_ctrl && !busy_r) begin
        ready_r <= 1'b0;
        ctrl_r[31:2] <= new_ctrl[31:2];
        if (!new_ctrl[dmae_pkg::START_BIT]) begin
          armed_r <= 1'b0;
        end else if (!new_map_ok) begin
          ctrl_r[dmae_pkg::FAULT_BIT] <= 1'b1;
          ctrl_r[dmae_pkg::VALID_BIT] <= 1'b0;
          ctrl_r[dmae_pkg::START_BIT] <= 1'b0;
          armed_r <= 1'b0;
        end else begin
          armed_r <= 1'b1;
          beats_r <= init_beats;
          cur_addr_r <= start_addr;
          ctrl_r[dmae_pkg::FAULT_BIT] <= 1'b0;
          ctrl_r[dmae_pkg::VALID_BIT] <=
            new_ctrl[dmae_pkg::DIR_BIT];
        end
      end
      if (wr_data && !busy_r) begin
        data_r <= shift_r;
      end
      if (go_rdn) begin
        ctrl_r[dmae_pkg::VALID_BIT] <= 1'b0;
      end
      if (go) begin
        busy_r <= 1'b1;
      end
    end
  end

  // Ready pin copy, registered on the test clock.
  assign ready_o = ready_r;

  // Launch crosses to the system clock as a toggle.
  dmae_pulse_sync u_go_sync (
    .clk_i(clk_sys_i),
    .rst_i(sys_rst_i),
    .tgl_i(go_tgl_r),
    .pulse_o(go_sys_p)
  );

  // Bus sequencer: one access per launch, held until acknowledged.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      bus_st_r <= dmae_pkg::DMAE_IDLE;
      bus_valid_r <= 1'b0;
      bus_req_r <= '0;
      rsp_data_r <= dmae_pkg::REG_RESET;
      rsp_err_r <= 1'b0;
      done_tgl_r <= 1'b0;
    end else begin
      unique case (bus_st_r)
        dmae_pkg::DMAE_IDLE: begin
          if (go_sys_p) begin
            bus_req_r <= req_r;
            bus_valid_r <= 1'b1;
            bus_st_r <= dmae_pkg::DMAE_BUSY;
          end
        end
        dmae_pkg::DMAE_BUSY: begin
          if (bus_ack_i) begin
            bus_valid_r <= 1'b0;
            rsp_data_r <= bus_rdata_i;
            rsp_err_r <= bus_err_i;
            done_tgl_r <= !done_tgl_r;
            bus_st_r <= dmae_pkg::DMAE_IDLE;
          end
        end
      endcase
    end
  end

  // Bus outputs straight from the sequencer's flops.
  assign bus_valid_o = bus_valid_r;
  assign bus_req_o = bus_req_r;

endmodule : dmae_engine

/* design/dmae_pkg.sv */
package dmae_pkg;

  // Register indices selected by the first data-register pass.
  localparam logic [6:0] IDX_CTRL = 7'h07;
  localparam logic [6:0] IDX_ADDR = 7'h09;
  localparam logic [6:0] IDX_DATA = 7'h0a;

  // Widths of the selector pass, the registers and the count field.
  localparam int SEL_W = 8;
  localparam int REG_W = 32;
  localparam int CNT_W = 14;

  // Field positions in the control/status register.
  localparam int START_BIT = 31;
  localparam int DIR_BIT = 30;
  localparam int WID_HI = 29;
  localparam int WID_LO = 27;
  localparam int MAP_HI = 26;
  localparam int MAP_LO = 24;
  localparam int PRIO_HI = 23;
  localparam int PRIO_LO = 22;
  localparam int BURST_BIT = 21;
  localparam int CNT_HI = 15;
  localparam int CNT_LO = 2;
  localparam int FAULT_BIT = 1;
  localparam int VALID_BIT = 0;

  // Writable control bits; reserved and status bits are masked off.
  localparam logic [31:0] CTRL_WMASK = 32'hffe0_fffc;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // Transfer width codes; codes above the doubleword act as word.
  localparam logic [2:0] WID_BYTE = 3'h0;
  localparam logic [2:0] WID_HALF = 3'h1;
  localparam logic [2:0] WID_DWORD = 3'h3;

  // Bus size codes driven to the system bus.
  localparam logic [1:0] BSZ_BYTE = 2'h0;
  localparam logic [1:0] BSZ_HALF = 2'h1;
  localparam logic [1:0] BSZ_WORD = 2'h2;

  // Memory space, urgency and burst alignment.
  localparam logic [2:0] MAP_PRIMARY = 3'h0;
  localparam logic [1:0] PRIO_HIGH = 2'h3;
  localparam logic [31:0] BURST_ALIGN = 32'hffff_fff8;

  // Bus-side sequencer states.
  typedef enum logic [0:0] {
    DMAE_IDLE = 1'b0,
    DMAE_BUSY = 1'b1
  } dmae_bus_st_t;

  // One system bus access as issued by the engine.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic we;
    logic [1:0] size;
    logic hi_prio;
    logic burst;
  } dmae_bus_req_t;

endpackage : dmae_pkg

/* design/dmae_pulse_sync.sv */
`timescale 1ns/1ps
module dmae_pulse_sync (
  // Destination clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Toggle from the source domain.
  input wire logic tgl_i,
  // One-cycle pulse per toggle.
  output logic pulse_o
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Two flops resynchronise the toggle, a third detects its edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= tgl_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  // Each change of the settled toggle is one event.
  assign pulse_o = sync_r ^ last_r;

endmodule : dmae_pulse_sync

/* verif/dmae_bus_mem.sv */
`timescale 1ns/1ps
module dmae_bus_mem (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Request from the engine and scenario controls.
  input wire logic bus_valid_i,
  input wire logic [31:0] addr_i,
  input wire logic err_en_i,
  input wire logic slow_i,
  // Answer to the engine.
  output logic ack_o,
  output logic err_o,
  output logic [31:0] rdata_o
);
  logic [2:0] wait_r;

  // Acks one access after a short or long wait; data toggles when idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_r <= 3'h0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
    end else if (bus_valid_i && !ack_o
                 && wait_r >= (slow_i ? 3'h4 : 3'h0)) begin
      ack_o <= 1'b1;
      err_o <= err_en_i;
      rdata_o <= {addr_i[15:0], ~addr_i[31:16]};
      wait_r <= 3'h0;
    end else begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= ~rdata_o;
      wait_r <= (bus_valid_i && !ack_o) ? wait_r + 3'h1 : 3'h0;
    end
  end
endmodule : dmae_bus_mem

/* verif/dmae_engine_checker.sv */
`timescale 1ns/1ps
module dmae_engine_checker #(
  parameter int CNT_W = 14
) (
  // Clocks and reset.
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic tck_i,
  // Scan port.
  input wire logic tdi_i,
  input wire logic dr_capture_i,
  input wire logic dr_shift_i,
  input wire logic dr_update_i,
  input wire logic tdo_o,
  input wire logic ready_o,
  // System bus.
  input wire logic bus_valid_o,
  input wire dmae_pkg::dmae_bus_req_t bus_req_o,
  input wire logic bus_ack_i,
  input wire logic bus_err_i,
  input wire logic [31:0] bus_rdata_i
);
  // Bus-side checks share the system clock and reset.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  property p_rst;
    disable iff (1'b0) sys_rst_i |=> !bus_valid_o && bus_req_o == '0;
  endproperty
  a_rst: assert property (p_rst)
    else $error("bus not idle in reset");
  property p_rdy_rst;
    @(posedge tck_i) disable iff (1'b0) sys_rst_i [*4] |-> !ready_o && !tdo_o;
  endproperty
  a_rdy_rst: assert property (p_rdy_rst)
    else $error("port not reset");
  property p_hold;
    bus_valid_o && !bus_ack_i |=> bus_valid_o && $stable(bus_req_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request not held");
  property p_drop;
    bus_valid_o && bus_ack_i |=> !bus_valid_o;
  endproperty
  a_drop: assert property (p_drop)
    else $error("valid kept after ack");
  property p_gap;
    $fell(bus_valid_o) |-> !bus_valid_o [*3];
  endproperty
  a_gap: assert property (p_gap)
    else $error("access too soon");
  property p_size;
    bus_valid_o |-> bus_req_o.size != 2'h3;
  endproperty
  a_size: assert property (p_size)
    else $error("illegal bus size");
  property p_align;
    bus_valid_o && bus_req_o.burst && bus_req_o.size == dmae_pkg::BSZ_WORD
      |-> bus_req_o.addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align)
    else $error("burst beat unaligned");
  property p_tdo;
    @(posedge tck_i) !dr_capture_i && !dr_shift_i && !dr_update_i
      |=> $stable(tdo_o);
  endproperty
  a_tdo: assert property (p_tdo)
    else $error("scan out moved idle");

  // Main scenarios reached.
  c_wr: cover property (bus_valid_o && bus_ack_i && bus_req_o.we);
  c_rd: cover property (bus_valid_o && bus_ack_i && !bus_req_o.we);
  c_err: cover property (bus_valid_o && bus_ack_i && bus_err_i);
  c_rdy: cover property (@(posedge tck_i) $rose(ready_o));
endmodule : dmae_engine_checker

bind dmae_engine dmae_engine_checker #(.CNT_W(CNT_W))
  dmae_engine_checker_inst (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i),
  .tdi_i(tdi_i), .dr_capture_i(dr_capture_i), .dr_shift_i(dr_shift_i),
  .dr_update_i(dr_update_i), .tdo_o(tdo_o), .ready_o(ready_o),
  .bus_valid_o(bus_valid_o), .bus_req_o(bus_req_o), .bus_ack_i(bus_ack_i),
  .bus_err_i(bus_err_i), .bus_rdata_i(bus_rdata_i)
);

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int W = $bits(dmae_pkg::dmae_bus_req_t);
  localparam logic [31:0] M = dmae_pkg::CTRL_WMASK & 32'h7fff_ffff;
  logic clk_sys_i = 1'b0, tck_i = 1'b0, sys_rst_i = 1'b1, tdi_i = 1'b0;
  logic dr_capture_i = 1'b0, dr_shift_i = 1'b0, dr_update_i = 1'b0;
  logic tdo_o, ready_o, bus_valid_o, bus_ack_i, bus_err_i;
  logic mem_err = 1'b0, mem_slow = 1'b0;
  logic [31:0] bus_rdata_i, rnd = 32'h3add_a0c6, q = 32'h0000_0000, a, c, x;
  logic [6:0] ix [4] = '{dmae_pkg::IDX_CTRL, dmae_pkg::IDX_ADDR,
                         dmae_pkg::IDX_DATA, 7'h05};
  dmae_pkg::dmae_bus_req_t bus_req_o, e, exp_q[$];
  int n_errors = 0, n_tests = 0, n_acks = 0, k = 0, cyc = 0;

  // Two unrelated clocks: 5 ns system, 12 ns link.
  initial begin forever #2.5 clk_sys_i = ~clk_sys_i; end
  initial begin #1.3; forever #6 tck_i = ~tck_i; end

  dmae_engine #(.CNT_W(14)) dmae_engine_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i),
    .tdi_i(tdi_i), .dr_capture_i(dr_capture_i), .dr_shift_i(dr_shift_i),
    .dr_update_i(dr_update_i), .tdo_o(tdo_o), .ready_o(ready_o),
    .bus_valid_o(bus_valid_o), .bus_req_o(bus_req_o),
    .bus_ack_i(bus_ack_i), .bus_err_i(bus_err_i), .bus_rdata_i(bus_rdata_i));
  dmae_bus_mem dmae_bus_mem_inst (
    .clk_i(clk_sys_i), .rst_i(sys_rst_i), .bus_valid_i(bus_valid_o),
    .addr_i(bus_req_o.addr), .err_en_i(mem_err), .slow_i(mem_slow),
    .ack_o(bus_ack_i), .err_o(bus_err_i), .rdata_o(bus_rdata_i));

  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function logic [31:0] ctl(input logic dir, input logic [2:0] wid,
                            input logic [1:0] pr, input logic b,
                            input logic [13:0] n);
    return {1'b1, dir, wid, 3'h0, pr, b, 5'h00, n, 2'h0};
  endfunction : ctl

  task chk(input logic [W-1:0] got, input logic [W-1:0] ex);
    n_tests++;
    if (got !== ex) begin
      n_errors++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, ex);
    end
  endtask : chk

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  // One scan pass: capture, shift n bits LSB first, update.
  task pass(input int n, input logic [31:0] v);
    @(negedge tck_i) dr_capture_i = 1'b1;
    for (int i = 0; i < n; i++) begin
      @(negedge tck_i) dr_capture_i = 1'b0;
      dr_shift_i = 1'b1;
      tdi_i = v[i];
      q[i] = tdo_o;
    end
    @(negedge tck_i) dr_shift_i = 1'b0;
    dr_update_i = 1'b1;
    @(negedge tck_i) dr_update_i = 1'b0;
  endtask : pass

  // Selector pass then data pass; read data lands in q.
  task acc(input logic [6:0] idx, input logic wr, input logic [31:0] d);
    pass(8, {idx, wr});
    pass(32, d);
  endtask : acc

  task exp_bus(input logic [31:0] ad, input logic [31:0] d, input logic we,
               input logic [1:0] sz, input logic hp, input logic b);
    exp_q.push_back('{addr: ad, wdata: d, we: we, size: sz, hi_prio: hp,
                      burst: b});
  endtask : exp_bus

  // Waits for the next bus ack, then lets status cross back.
  task settle;
    k++;
    for (int t = 0; t < 400 && n_acks < k; t++) @(negedge tck_i);
    repeat (10) @(negedge tck_i);
  endtask : settle

  // Bus monitor compares every acked access with the oldest note.
  // It samples mid-cycle, where the registered bus signals have settled.
  always @(negedge clk_sys_i) begin
    if (bus_valid_o === 1'b1 && bus_ack_i === 1'b1) begin
      n_acks++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
      if (e.we === 1'b0) e.wdata = bus_req_o.wdata;
      chk(W'(bus_req_o), W'(e));
    end
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      test_done();
    end
  end

  initial begin
    repeat (10) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge tck_i);
    for (int i = 0; i < 4; i++) begin
      acc(ix[i], 1'b0, rnd);
      chk(W'(q), W'(32'h0000_0000));
    end
    acc(dmae_pkg::IDX_CTRL, 1'b1, 32'h7fff_ffff);
    acc(dmae_pkg::IDX_CTRL, 1'b0, 32'h0000_0000);
    chk(W'(q), W'(M));
    $display("reset and reserved test done");
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr(rnd);
      a = rnd;
      rnd = lfsr(rnd);
      mem_slow = rnd[0];
      c = ctl(1'b1, (i < 3) ? 3'(i) : 3'(i + 2), i[1:0], 1'b0, 14'(i[0]));
      acc(dmae_pkg::IDX_ADDR, 1'b1, a);
      acc(dmae_pkg::IDX_CTRL, 1'b1, c);
      acc(dmae_pkg::IDX_CTRL, 1'b0, 32'h0000_0000);
      chk(W'(q), W'(c | 32'h0000_0001));
      exp_bus(a, rnd, 1'b1, (i < 2) ? 2'(i) : dmae_pkg::BSZ_WORD,
              i == 3, 1'b0);
      acc(dmae_pkg::IDX_DATA, 1'b1, rnd);
      settle();
      acc(dmae_pkg::IDX_CTRL, 1'b0, 32'h0000_0000);
      chk(W'(q), W'(c & M));
      chk(W'(ready_o), W'(1'b1));
    end
    $display("single write test done");
    for (int b = 0; b < 2; b++) begin
      mem_slow = b[0];
      c = ctl(1'b0, b ? dmae_pkg::WID_DWORD : 3'h2, 2'h3, b[0],
              b ? 14'h2 : 14'h1);
      for (int j = 0; j < (b ? 4 : 1); j++)
        exp_bus((b ? a & dmae_pkg::BURST_ALIGN : a) + 32'(4 * j), 32'h0,
                1'b0, dmae_pkg::BSZ_WORD, 1'b1, b[0]);
      acc(dmae_pkg::IDX_CTRL, 1'b1, c);
      for (int j = 0; j < (b ? 4 : 1); j++) begin
        settle();
        // Each beat returns the data the memory model ties to its address.
        x = (b ? a & dmae_pkg::BURST_ALIGN : a) + 32'(4 * j);
        acc(dmae_pkg::IDX_DATA, 1'b0, 32'h0000_0000);
        chk(W'(q), W'({x[15:0], ~x[31:16]}));
      end
      acc(dmae_pkg::IDX_CTRL, 1'b0, 32'h0000_0000);
      chk(W'(q), W'((c & M) | 32'h0000_0001));
    end
    $display("read test done");
    mem_err = 1'b1;
    c = ctl(1'b0, 3'h2, 2'h0, 1'b0, 14'h1);
    exp_bus(a, 32'h0, 1'b0, dmae_pkg::BSZ_WORD, 1'b0, 1'b0);
    acc(dmae_pkg::IDX_CTRL, 1'b1, c);
    settle();
    mem_err = 1'b0;
    acc(dmae_pkg::IDX_CTRL, 1'b0, 32'h0000_0000);
    chk(W'(q), W'((c & M) | 32'h0000_0002));
    chk(W'(ready_o), W'(1'b0));
    c = c | 32'h0100_0000;
    acc(dmae_pkg::IDX_CTRL, 1'b1, c);
    repeat (20) @(negedge tck_i);
    acc(dmae_pkg::IDX_CTRL, 1'b0, 32'h0000_0000);
    chk(W'(q), W'((c & M) | 32'h0000_0002));
    chk(W'(exp_q.size()), W'(0));
    $display("fault test done");
    test_done();
  end
endmodule : testbench
